//--- scsr_defines.vh
/*
 Constants for the serializer control and status register bank:
 register offsets, field positions, reset values and timing units.
 Assumes it is included by its bare name from each design file.
*/
`ifndef SCSR_DEFINES_VH
`define SCSR_DEFINES_VH

// Register offsets
`define SCSR_ADDR_PASSTHRU      8'h17
`define SCSR_ADDR_CLK_HIGH      8'h18
`define SCSR_ADDR_CLK_LOW       8'h19
`define SCSR_ADDR_PAYLOAD_AUDIO 8'h1a
`define SCSR_ADDR_BC_ERRORS     8'h1b
`define SCSR_ADDR_IO_LOW        8'h1c
`define SCSR_ADDR_IO_HIGH       8'h1d

// Reset values
`define SCSR_RST_PASSTHRU       8'h1e
`define SCSR_RST_CLK_HIGH       8'ha1
`define SCSR_RST_CLK_LOW        8'ha5
`define SCSR_RST_PAYLOAD_AUDIO  8'h00

// Field positions
`define SCSR_PASS_ALL_BIT       7
`define SCSR_HOLD_MSB           6
`define SCSR_HOLD_LSB           4
`define SCSR_FILT_MSB           3
`define SCSR_FILT_LSB           0
`define SCSR_AUDIO_LOCK_BIT     7
`define SCSR_WIDE_BIT           1
`define SCSR_SURROUND_BIT       0
`define SCSR_CFG12_FOURCH_BIT   3
`define SCSR_CFG12_AUX_BIT      0

// Timing, in ns; 16 bits wide so field products never overflow
`define SCSR_CLK_PERIOD_NS      16'h0028
`define SCSR_HOLD_UNIT_NS       16'h0028
`define SCSR_FILT_UNIT_NS       16'h0005

// Counter ceiling
`define SCSR_BC_ERR_MAX         8'hff

`endif

//--- scsr_glitch_filter.v
/*
 One glitch filter for a synchronised bus line.
 Assumes the input is already synchronised to clk.
*/
`timescale 1ns/100ps
`include "scsr_defines.vh"

module scsr_glitch_filter #(
   parameter CW = 3
) (
   input  wire          clk,
   input  wire          reset_n,
   input  wire          line_in,
   input  wire [CW-1:0] depth_cycles,
   output reg           line_q
);

   reg [CW-1:0] stable_q;

   // The output moves only after the new level outlasts the depth
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_q   <= 1'b1;
         stable_q <= {CW{1'b0}};
      end else if (line_in == line_q) begin
         stable_q <= {CW{1'b0}};
      end else if (stable_q >= depth_cycles) begin
         line_q   <= line_in;
         stable_q <= {CW{1'b0}};
      end else begin
         stable_q <= stable_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end

endmodule

//--- scsr_regs.v
/*
 Control and status register bank of the serializer, offsets 0x17 to 0x1d,
 with bus-line conditioning, master clock timing, forwarding decision,
 payload and audio mode selection and the self-test error counters.
 Assumes the serial bus slave engine presents decoded register accesses
 on the clk domain and that the neighbouring registers feed their bits in.
*/
// What this block does
// - Pass-all clear: forward only accesses to remote deserializer or remote target ID.
// - Pass-all set: forward every access not aimed at our own ID.
// - Delay data input against clock input by hold field, 40 ns steps.
// - Reject clock and data glitches up to filter field width, 5 ns steps.
// - Audio lock clear: repeater takes audio format from in-band signalling.
// - Wide payload selects 28-bit data, else 24-bit plus three controls.
// - Surround bit gives 5.1/7.1 audio, else 2/4 channel from 0x12 bits.
// - Surround audio always uses the data-island transport.
// - A repeater may override surround with the detected in-band format.
// - Count self-test back-channel CRC errors, 8 bits, saturating at 255.
// - Error counter clears on new self-test start or 0x04 bit 5 write.
// - Second-link select makes the counter read show the second link.
// - Status low shows lines 7..5 and 3..0, bit 4 reserved.
// - Status high shows line 8 in bit 0, others zero.
// - Status bits mean something only for pins set as inputs.
// - Second-link select shows far-link lines 3..0 in status bits 3..0.
// - Second-link select routes primary accesses, ignored if secondary address on.
`timescale 1ns/100ps
`include "scsr_defines.vh"

module scsr_regs (
   input  wire       clk,
   input  wire       reset_n,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_via_secondary,
   output reg  [7:0] reg_rdata_q,
   input  wire       second_link_select,
   input  wire       secondary_address_enable,
   input  wire       scl_pin,
   input  wire       sda_pin,
   output reg        scl_cond_q,
   output reg        sda_cond_q,
   input  wire       master_active,
   output reg        master_scl_oe_q,
   input  wire       target_valid,
   input  wire [6:0] target_id,
   input  wire [6:0] own_id,
   input  wire [6:0] remote_des_id,
   input  wire [6:0] remote_target_id,
   output reg        forward_valid_q,
   output reg        forward_q,
   input  wire       is_repeater,
   input  wire [1:0] inband_audio_fmt,
   input  wire [7:0] audio_cfg12,
   output reg        wide_payload_mode_q,
   output reg        low_speed_ctrl_en_q,
   output reg  [2:0] audio_mode_q,
   output reg        data_island_transport_q,
   input  wire       selftest_active,
   input  wire       selftest_start,
   input  wire       bc_err_clear,
   input  wire [1:0] bc_crc_err,
   input  wire [8:0] local_io_pins,
   input  wire [3:0] far_link_io_line
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and pin synchronisers

   reg  [7:0] passthru_q;
   reg  [7:0] clk_high_q;
   reg  [7:0] clk_low_q;
   reg  [7:0] payload_audio_q;
   reg  [7:0] bc_err0_q;
   reg  [7:0] bc_err1_q;
   reg  [1:0] scl_sync_q;
   reg  [1:0] sda_sync_q;
   reg  [8:0] io_meta_q;
   reg  [8:0] io_sync_q;
   reg  [7:0] sda_delay_q;
   reg  [7:0] mclk_cnt_q;
   reg        mclk_low_q;
   wire       scl_filt;
   wire       sda_filt;

   wire second_link_view = reg_via_secondary ? secondary_address_enable
                                             : (second_link_select & ~secondary_address_enable);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         passthru_q      <= `SCSR_RST_PASSTHRU;
         clk_high_q      <= `SCSR_RST_CLK_HIGH;
         clk_low_q       <= `SCSR_RST_CLK_LOW;
         payload_audio_q <= `SCSR_RST_PAYLOAD_AUDIO;
      end else if (reg_wr) begin
         case (reg_addr)
            `SCSR_ADDR_PASSTHRU:      passthru_q <= reg_wdata;
            `SCSR_ADDR_CLK_HIGH:      clk_high_q <= reg_wdata;
            `SCSR_ADDR_CLK_LOW:       clk_low_q  <= reg_wdata;
            // Reserved bits 6:2 hold zero
            `SCSR_ADDR_PAYLOAD_AUDIO: payload_audio_q <= reg_wdata & 8'h83;
            default: ;
         endcase
      end
   end

   // Two flops on every pin before any logic
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_sync_q <= 2'b11;
         sda_sync_q <= 2'b11;
         io_meta_q  <= 9'h000;
         io_sync_q  <= 9'h000;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_pin};
         sda_sync_q <= {sda_sync_q[0], sda_pin};
         io_meta_q  <= local_io_pins;
         io_sync_q  <= io_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus line conditioning

   // Depth rounds up: a glitch of the set width must still be rejected
   wire [3:0] filt_field = passthru_q[`SCSR_FILT_MSB:`SCSR_FILT_LSB];
   wire [15:0] filt_ns   = {12'h000, filt_field} * `SCSR_FILT_UNIT_NS;
   wire [15:0] filt_cyc  = (filt_ns + `SCSR_CLK_PERIOD_NS - 16'h0001) / `SCSR_CLK_PERIOD_NS;

   scsr_glitch_filter #(.CW(3)) u_scl_filter (
      .clk          (clk),
      .reset_n      (reset_n),
      .line_in      (scl_sync_q[1]),
      .depth_cycles (filt_cyc[2:0]),
      .line_q       (scl_filt)
   );

   scsr_glitch_filter #(.CW(3)) u_sda_filter (
      .clk          (clk),
      .reset_n      (reset_n),
      .line_in      (sda_sync_q[1]),
      .depth_cycles (filt_cyc[2:0]),
      .line_q       (sda_filt)
   );

   wire [2:0] hold_field = passthru_q[`SCSR_HOLD_MSB:`SCSR_HOLD_LSB];
   wire [15:0] hold_cyc  = ({13'h0000, hold_field} * `SCSR_HOLD_UNIT_NS) / `SCSR_CLK_PERIOD_NS;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_delay_q <= 8'hff;
         scl_cond_q  <= 1'b1;
         sda_cond_q  <= 1'b1;
      end else begin
         sda_delay_q <= {sda_delay_q[6:0], sda_filt};
         scl_cond_q  <= scl_filt;
         sda_cond_q  <= (hold_cyc[2:0] == 3'd0) ? sda_filt : sda_delay_q[hold_cyc[2:0] - 3'd1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Master clock timing

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mclk_cnt_q      <= 8'h00;
         mclk_low_q      <= 1'b0;
         master_scl_oe_q <= 1'b0;
      end else if (!master_active) begin
         mclk_cnt_q      <= 8'h00;
         mclk_low_q      <= 1'b0;
         master_scl_oe_q <= 1'b0;
      end else if (mclk_cnt_q >= (mclk_low_q ? clk_low_q : clk_high_q)) begin
         mclk_cnt_q      <= 8'h00;
         mclk_low_q      <= ~mclk_low_q;
         master_scl_oe_q <= ~mclk_low_q;
      end else begin
         mclk_cnt_q      <= mclk_cnt_q + 8'h01;
         master_scl_oe_q <= mclk_low_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Forwarding decision

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         forward_valid_q <= 1'b0;
         forward_q       <= 1'b0;
      end else begin
         forward_valid_q <= target_valid;
         if (target_valid) begin
            if (passthru_q[`SCSR_PASS_ALL_BIT]) begin
               forward_q <= (target_id != own_id);
            end else begin
               forward_q <= (target_id == remote_des_id) || (target_id == remote_target_id);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Payload and audio modes

   wire audio_lock  = payload_audio_q[`SCSR_AUDIO_LOCK_BIT];
   wire auto_detect = is_repeater & ~audio_lock;
   wire surround    = auto_detect ? (inband_audio_fmt == 2'd2)
                                  : payload_audio_q[`SCSR_SURROUND_BIT];
   wire four_ch     = auto_detect ? (inband_audio_fmt == 2'd1)
                                  : (audio_cfg12[`SCSR_CFG12_FOURCH_BIT] |
                                     audio_cfg12[`SCSR_CFG12_AUX_BIT]);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wide_payload_mode_q     <= 1'b0;
         low_speed_ctrl_en_q     <= 1'b1;
         audio_mode_q            <= 3'b001;
         data_island_transport_q <= 1'b0;
      end else begin
         wide_payload_mode_q <= payload_audio_q[`SCSR_WIDE_BIT];
         low_speed_ctrl_en_q <= ~payload_audio_q[`SCSR_WIDE_BIT];
         if (surround) begin
            audio_mode_q <= 3'b100;
         end else if (four_ch) begin
            audio_mode_q <= 3'b010;
         end else begin
            audio_mode_q <= 3'b001;
         end
         data_island_transport_q <= surround;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-test error counters

   // Clear on start or strobe; an error in the same cycle counts
   wire bc_clr = selftest_start | bc_err_clear;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bc_err0_q <= 8'h00;
         bc_err1_q <= 8'h00;
      end else begin
         if (bc_clr) begin
            bc_err0_q <= {7'h00, bc_crc_err[0] & selftest_active};
            bc_err1_q <= {7'h00, bc_crc_err[1] & selftest_active};
         end else if (selftest_active) begin
            if (bc_crc_err[0] && bc_err0_q != `SCSR_BC_ERR_MAX) begin
               bc_err0_q <= bc_err0_q + 8'h01;
            end
            if (bc_crc_err[1] && bc_err1_q != `SCSR_BC_ERR_MAX) begin
               bc_err1_q <= bc_err1_q + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Low status layout; far-link lines on second link
   wire [3:0] low_lines = second_link_view ? far_link_io_line : io_sync_q[3:0];
   // Output pins read whatever the pad shows
   wire [7:0] io_low    = {io_sync_q[7:5], 1'b0, low_lines};
   wire [7:0] io_high   = {7'h00, io_sync_q[8]};

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `SCSR_ADDR_PASSTHRU:      reg_rdata_q <= passthru_q;
            `SCSR_ADDR_CLK_HIGH:      reg_rdata_q <= clk_high_q;
            `SCSR_ADDR_CLK_LOW:       reg_rdata_q <= clk_low_q;
            `SCSR_ADDR_PAYLOAD_AUDIO: reg_rdata_q <= payload_audio_q;
            `SCSR_ADDR_BC_ERRORS:     reg_rdata_q <= second_link_view ? bc_err1_q : bc_err0_q;
            `SCSR_ADDR_IO_LOW:        reg_rdata_q <= io_low;
            `SCSR_ADDR_IO_HIGH:       reg_rdata_q <= io_high;
            default:                  reg_rdata_q <= 8'h00;
         endcase
      end
   end

endmodule

//--- scsr_regs_asserts.sv
/*
 Checker for scsr_regs: forwarding, mode outputs and master clock timing.
 Assumes it is bound into scsr_regs and that writes take effect at their edge.
*/
`timescale 1ns/100ps
module scsr_regs_asserts (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       target_valid,
   input wire logic [6:0] target_id,
   input wire logic [6:0] own_id,
   input wire logic [6:0] remote_des_id,
   input wire logic [6:0] remote_target_id,
   input wire logic       forward_valid_q,
   input wire logic       forward_q,
   input wire logic       is_repeater,
   input wire logic [1:0] inband_audio_fmt,
   input wire logic       wide_payload_mode_q,
   input wire logic       low_speed_ctrl_en_q,
   input wire logic [2:0] audio_mode_q,
   input wire logic       data_island_transport_q,
   input wire logic       master_active,
   input wire logic       master_scl_oe_q
);
   logic       pass_q;
   logic       sur_q;
   logic       lock_q;
   logic [7:0] clo_q;
   logic [8:0] lo_run_q;
   wire        near_m = (target_id == remote_des_id) || (target_id == remote_target_id);

   // Shadows of register fields, since the bank itself is hidden here
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pass_q <= 1'b0;
         sur_q <= 1'b0;
         lock_q <= 1'b0;
         clo_q <= 8'ha5;
         lo_run_q <= 9'h000;
      end else begin
         if (reg_wr && reg_addr == 8'h17) pass_q <= reg_wdata[7];
         if (reg_wr && reg_addr == 8'h1a) sur_q <= reg_wdata[0];
         if (reg_wr && reg_addr == 8'h1a) lock_q <= reg_wdata[7];
         if (reg_wr && reg_addr == 8'h19) clo_q <= reg_wdata;
         lo_run_q <= master_scl_oe_q ? lo_run_q + 9'h001 : 9'h000;
      end
   end
   //////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_surround_held;
      (!is_repeater && sur_q) [*3];
   endsequence
   sequence s_auto_fourch;
      (is_repeater && !lock_q && inband_audio_fmt == 2'h1) [*3];
   endsequence

   a_fwd_answer_pulse: assert property (forward_valid_q == $past(target_valid))
      else $error("forward answer not one cycle after request");
   a_fwd_strict_ids: assert property (target_valid && !pass_q |=> forward_q == $past(near_m))
      else $error("filtered forwarding decision wrong");
   a_fwd_pass_all: assert property (target_valid && pass_q |=> forward_q == $past(target_id != own_id))
      else $error("pass-all forwarding decision wrong");
   a_wide_mode_sel: assert property (reg_wr && reg_addr == 8'h1a |-> ##2
      wide_payload_mode_q == $past(reg_wdata[1], 2) && low_speed_ctrl_en_q != wide_payload_mode_q)
      else $error("payload mode does not follow written bit");
   a_island_follow: assert property (data_island_transport_q == audio_mode_q[2])
      else $error("surround not on island transport");
   a_surround_sel: assert property (s_surround_held |-> audio_mode_q == 3'h4)
      else $error("surround bit not applied");
   a_repeater_auto: assert property (s_auto_fourch |-> audio_mode_q == 3'h2)
      else $error("in-band audio format not applied");
   a_clk_low_count: assert property (master_active && $fell(master_scl_oe_q) |->
      lo_run_q == {1'b0, clo_q} + 9'h001)
      else $error("clock low phase length wrong");
   a_master_idle: assert property (!master_active [*2] |-> !master_scl_oe_q)
      else $error("clock driven while not master");
endmodule

//--- scsr_host.sv
/*
 Host side model: the slave engine handing decoded byte accesses to the bank.
 Assumes clk is the bank clock; requests change at falling edges.
*/
`timescale 1ns/100ps
module scsr_host (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata_q,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_via_secondary
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_via_secondary = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // Stale data is inverted so nothing leans on it
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata_q;
   endtask
endmodule

//--- scsr_regs_tb_top.sv
/*
 Testbench for scsr_regs: register, forwarding, mode, counter, status and line tests.
 Assumes scsr_host and the checker are compiled alongside.
*/
`timescale 1ns/100ps
module scsr_regs_tb_top;
   logic       clk, reset_n = 1'b0, scl_pin = 1'b1, sda_pin = 1'b1;
   logic       second_link_select = 1'b0, secondary_address_enable = 1'b0;
   logic       master_active = 1'b0, target_valid = 1'b0, is_repeater = 1'b0;
   logic       selftest_active = 1'b0, selftest_start = 1'b0, bc_err_clear = 1'b0;
   logic [6:0] target_id = 7'h00, own_id = 7'h10, remote_des_id = 7'h20;
   logic [6:0] remote_target_id = 7'h30;
   logic [1:0] inband_audio_fmt = 2'h0, bc_crc_err = 2'h0;
   logic [7:0] audio_cfg12 = 8'h00, reg_addr, reg_wdata, reg_rdata_q;
   logic [8:0] local_io_pins = 9'h000;
   logic [3:0] far_link_io_line = 4'h0;
   logic [2:0] audio_mode_q;
   logic       reg_wr, reg_rd, reg_via_secondary, scl_cond_q, sda_cond_q, master_scl_oe_q;
   logic       forward_valid_q, forward_q, wide_payload_mode_q, low_speed_ctrl_en_q;
   logic       data_island_transport_q, bad;
   int         n_mismatch = 0, tests_run = 0, n;

   scsr_regs u_scsr_regs (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_via_secondary, .reg_rdata_q, .second_link_select, .secondary_address_enable,
      .scl_pin, .sda_pin, .scl_cond_q, .sda_cond_q, .master_active, .master_scl_oe_q,
      .target_valid, .target_id, .own_id, .remote_des_id, .remote_target_id,
      .forward_valid_q, .forward_q, .is_repeater, .inband_audio_fmt, .audio_cfg12,
      .wide_payload_mode_q, .low_speed_ctrl_en_q, .audio_mode_q, .data_island_transport_q,
      .selftest_active, .selftest_start, .bc_err_clear, .bc_crc_err, .local_io_pins,
      .far_link_io_line);
   scsr_host u_scsr_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_via_secondary, .reg_rdata_q);

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_scsr_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic fwd(input logic [6:0] id, input logic exp);
      @(negedge clk);
      target_id = id;
      target_valid = 1'b1;
      @(negedge clk);
      target_valid = 1'b0;
      chk({7'h00, forward_q}, {7'h00, exp});
   endtask
   task automatic errs(input int k, input logic [1:0] b);
      repeat (k) @(negedge clk) bc_crc_err = b;
      @(negedge clk) bc_crc_err = 2'h0;
   endtask
   task automatic pls(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // A hang costs a mismatch; the tests need under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      rc(8'h17, 8'h1e);
      rc(8'h18, 8'ha1);
      rc(8'h19, 8'ha5);
      rc(8'h1a, 8'h00);
      u_scsr_host.wr(8'h1a, 8'hff);
      rc(8'h1a, 8'h83);
      u_scsr_host.wr(8'h1b, 8'h55);
      rc(8'h1b, 8'h00);
      $display("test 1 done");
      fwd(7'h20, 1'b1);
      fwd(7'h30, 1'b1);
      fwd(7'h40, 1'b0);
      u_scsr_host.wr(8'h17, 8'h9e);
      fwd(7'h40, 1'b1);
      fwd(7'h10, 1'b0);
      $display("test 2 done");
      settle();
      chk({7'h00, low_speed_ctrl_en_q}, 8'h00);
      chk({5'h00, audio_mode_q}, 8'h04);
      u_scsr_host.wr(8'h1a, 8'h00);
      audio_cfg12 = 8'h08;
      settle();
      chk({7'h00, wide_payload_mode_q}, 8'h00);
      chk({5'h00, audio_mode_q}, 8'h02);
      audio_cfg12 = 8'h01;
      settle();
      chk({5'h00, audio_mode_q}, 8'h02);
      audio_cfg12 = 8'h00;
      is_repeater = 1'b1;
      inband_audio_fmt = 2'h1;
      u_scsr_host.wr(8'h1a, 8'h01);
      settle();
      chk({5'h00, audio_mode_q}, 8'h02);
      u_scsr_host.wr(8'h1a, 8'h00);
      inband_audio_fmt = 2'h2;
      settle();
      chk({5'h00, audio_mode_q}, 8'h04);
      inband_audio_fmt = 2'h1;
      u_scsr_host.wr(8'h1a, 8'h81);
      settle();
      chk({7'h00, data_island_transport_q}, 8'h01);
      is_repeater = 1'b0;
      settle();
      chk({5'h00, audio_mode_q}, 8'h04);
      $display("test 3 done");
      selftest_active = 1'b1;
      errs(3, 2'h1);
      rc(8'h1b, 8'h03);
      second_link_select = 1'b1;
      errs(5, 2'h2);
      rc(8'h1b, 8'h05);
      second_link_select = 1'b0;
      rc(8'h1b, 8'h03);
      pls(bc_err_clear);
      rc(8'h1b, 8'h00);
      errs(260, 2'h1);
      rc(8'h1b, 8'hff);
      bc_crc_err = 2'h1;
      pls(selftest_start);
      bc_crc_err = 2'h0;
      rc(8'h1b, 8'h01);
      pls(selftest_start);
      rc(8'h1b, 8'h00);
      selftest_active = 1'b0;
      errs(2, 2'h1);
      rc(8'h1b, 8'h00);
      $display("test 4 done");
      local_io_pins = 9'h1ff;
      far_link_io_line = 4'h5;
      settle();
      rc(8'h1c, 8'hef);
      rc(8'h1d, 8'h01);
      second_link_select = 1'b1;
      rc(8'h1c, 8'he5);
      secondary_address_enable = 1'b1;
      rc(8'h1c, 8'hef);
      u_scsr_host.reg_via_secondary = 1'b1;
      rc(8'h1c, 8'he5);
      u_scsr_host.reg_via_secondary = 1'b0;
      second_link_select = 1'b0;
      $display("test 5 done");
      @(negedge clk) scl_pin = 1'b0;
      @(negedge clk) scl_pin = 1'b1;
      bad = 1'b0;
      repeat (8) @(negedge clk) if (scl_cond_q !== 1'b1) bad = 1'b1;
      chk({7'h00, bad}, 8'h00);
      scl_pin = 1'b0;
      sda_pin = 1'b0;
      repeat (8) @(negedge clk);
      chk({7'h00, scl_cond_q}, 8'h00);
      u_scsr_host.wr(8'h17, 8'h30);
      scl_pin = 1'b1;
      sda_pin = 1'b1;
      n = 0;
      while (scl_cond_q !== 1'b1 && n < 20) @(negedge clk) n++;
      n = 0;
      while (sda_cond_q !== 1'b1 && n < 20) @(negedge clk) n++;
      chk(n[7:0], 8'h03);
      $display("test 6 done");
      u_scsr_host.wr(8'h18, 8'h02);
      u_scsr_host.wr(8'h19, 8'h03);
      master_active = 1'b1;
      n = 0;
      while (master_scl_oe_q !== 1'b1 && n < 20) @(negedge clk) n++;
      chk(n[7:0], 8'h03);
      n = 0;
      while (master_scl_oe_q === 1'b1 && n < 20) @(negedge clk) n++;
      chk(n[7:0], 8'h04);
      repeat (40) @(negedge clk);
      master_active = 1'b0;
      settle();
      chk({7'h00, master_scl_oe_q}, 8'h00);
      $display("test 7 done");
      conclude();
   end
endmodule

bind scsr_regs scsr_regs_asserts u_chk (.clk, .reset_n, .reg_wr, .reg_addr, .reg_wdata,
   .target_valid, .target_id, .own_id, .remote_des_id, .remote_target_id,
   .forward_valid_q, .forward_q, .is_repeater, .inband_audio_fmt, .wide_payload_mode_q,
   .low_speed_ctrl_en_q, .audio_mode_q, .data_island_transport_q, .master_active,
   .master_scl_oe_q);
